// >>> hdl/stc_pkg.sv
package stc_pkg;
	// Block dimensions
	localparam int NEV = 6;
	localparam int NST = 8;
	localparam int NIO = 4;
	localparam int NMR = 5;
	localparam int HALF = 16;

	// Register byte offsets
	localparam logic [11:0] A_CFG = 12'h000;
	localparam logic [11:0] A_CTRL = 12'h004;
	localparam logic [11:0] A_MSK0 = 12'h008;
	localparam logic [11:0] A_COUNT = 12'h018;
	localparam logic [11:0] A_STATE = 12'h01C;
	localparam logic [11:0] A_INPUT = 12'h020;
	localparam logic [11:0] A_REGMODE = 12'h024;
	localparam logic [11:0] A_OUTPUT = 12'h028;
	localparam logic [11:0] A_EVFLAG = 12'h02C;
	localparam logic [11:0] A_MR0 = 12'h040;
	localparam logic [11:0] A_MR_END = 12'h054;
	localparam logic [11:0] A_EV0 = 12'h080;
	localparam logic [11:0] A_EV_END = 12'h0E0;
	localparam logic [1:0] EV_STM = 2'h0;
	localparam logic [1:0] EV_CTL = 2'h1;
	localparam logic [1:0] EV_ACT = 2'h2;

	// Field positions
	localparam int CFG_UNIFY = 0;
	localparam int CFG_INCLK = 1;
	localparam int CFG_INSEL = 2;
	localparam int CFG_ALIM = 4;
	localparam int CT_STOP = 0;
	localparam int CT_HALT = 1;
	localparam int CT_BIDIR = 2;
	localparam int CT_CLR = 3;

	// Reset values and write masks
	localparam logic [5:0] RST_CFG = 6'h00;
	localparam logic [31:0] MSK_WORD = 32'h003F_003F;
	localparam logic [1:0] RST_HALT = 2'h3;

	typedef enum logic [1:0] {
		STC_IO_LOW, STC_IO_RISE, STC_IO_FALL, STC_IO_HIGH
	} stc_iocond_t;
	typedef enum logic [1:0] {
		STC_CB_OR, STC_CB_MATCH, STC_CB_IO, STC_CB_AND
	} stc_comb_t;
	typedef enum logic [1:0] {
		STC_DIR_ANY, STC_DIR_UP, STC_DIR_DOWN, STC_DIR_NONE
	} stc_dir_t;

	// Event control word, LSB is msel
	typedef struct packed {
		stc_dir_t dir;
		logic hold;
		logic [2:0] stv;
		logic stld;
		stc_comb_t comb;
		stc_iocond_t cond;
		logic isout;
		logic [1:0] iosel;
		logic half;
		logic [2:0] msel;
	} stc_evctl_t;

	// Event action word, LSB is toggle mask
	typedef struct packed {
		logic dma;
		logic irq;
		logic [4:0] cap;
		logic [3:0] tog;
	} stc_evact_t;
endpackage

// >>> hdl/stc_core.sv
`timescale 1ns/10ps
// Overview of operation
// - Six events, eight states, four inputs and four outputs.
// - One 32-bit counter or two 16-bit halves on one shared tick.
// - Counter tick from system clock or a chosen input's rising edge.
// - Each counter counts up only or up then down.
// - Five registers, each set as match or capture.
// - Match can interrupt, stop, limit, halt, reverse or toggle outputs.
// - Capture copies counter value on a configured event.
// - Four PWM outputs sharing one period, each own duty.
// - Event is match, input/output edge or level, or combination.
// - Events may limit, halt, start, stop or reverse a counter.
// - Events drive state changes, toggles, interrupt and DMA requests.
// - Match register zero may act as automatic limit.
// - In up-down mode events qualify by count direction.
// - Match may be held until the event's other condition arrives.
// - Each event has a per-state enable mask.
// - Enabled event may load a programmed new state.
// - State survives counter wrap and limit.
// - Outputs ORed with other timers' matches form ADC trigger.
// - With one state the block is a plain timer.
module stc_core (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Sync reset, high
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB write
	input wire logic [11:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error, unmapped
	input wire logic [stc_pkg::NIO-1:0] pin_in, // Async inputs
	input wire logic [stc_pkg::NIO-1:0] gp_match_in, // Other timers
	output logic [stc_pkg::NIO-1:0] pin_out, // Timer outputs
	output logic adc_trig_out, // ADC trigger
	output logic irq_out, // Interrupt level
	output logic [stc_pkg::NEV-1:0] dma_req_out // DMA pulses
);
	localparam int NEV = stc_pkg::NEV;
	localparam int NIO = stc_pkg::NIO;
	localparam int NMR = stc_pkg::NMR;

	logic [NIO-1:0] s1_q, s2_q, s3_q, in_q, inp_q, in_d;
	logic [NIO-1:0] out_q, outp_q, out_d, tg;
	logic [5:0] cfg_q;
	logic [31:0] msk_q [4];
	logic [31:0] mr_q [NMR];
	logic [NMR-1:0] capm_q, cp;
	logic [7:0] evs_q [NEV];
	stc_pkg::stc_evctl_t evc_q [NEV];
	stc_pkg::stc_evact_t eva_q [NEV];
	logic [15:0] cnt_q [2];
	logic [15:0] nxt [2];
	logic [2:0] state_q [2];
	logic [2:0] state_d [2];
	logic [1:0] dir_q, stop_q, halt_q, bid_q;
	logic [1:0] adv, run, lim, clr, hset, sset, sclr;
	logic [NEV-1:0] ev, ev_hi, ev_irq, ev_dma, flag_q, mlat_q;
	logic [NMR-1:0] mtq [2];
	logic [31:0] prdata_q, rd;
	logic pready_q, pslverr_q, irq_q, adc_q;
	logic [NEV-1:0] dma_q;

	// Counter step: returns {direction, count}
	function automatic logic [32:0] stc_step(logic [31:0] c, logic bid,
		logic dn, logic lm);
		logic [32:0] r;
		r = {dn, c + 32'h1};
		if (bid) begin
			if (!dn && lm) begin
				r = {1'b1, c - 32'h1};
			end else if (dn && c == 32'h0) begin
				r = {1'b0, c + 32'h1};
			end else if (dn) begin
				r = {1'b1, c - 32'h1};
			end
		end else if (lm) begin
			r = {1'b0, 32'h0};
		end
		return r;
	endfunction

	// Event register index from address
	function automatic logic [2:0] stc_evix(logic [11:0] a);
		return 3'((a - stc_pkg::A_EV0) >> 4);
	endfunction

	// APB decode; one wait state, so ready comes from a flop
	logic acc, wr, a_ev, a_mr, hit;
	logic [11:0] a;
	logic [2:0] ei, mi;
	logic [1:0] sub;
	assign a = paddr_in;
	assign acc = psel_in & penable_in & ~pready_q;
	// Refused addresses must not write, unaligned ones included
	assign wr = psel_in & penable_in & pready_q & pwrite_in & hit;
	assign a_ev = (a >= stc_pkg::A_EV0) && (a < stc_pkg::A_EV_END);
	assign a_mr = (a >= stc_pkg::A_MR0) && (a < stc_pkg::A_MR_END);
	assign ei = stc_evix(a);
	assign mi = 3'((a - stc_pkg::A_MR0) >> 2);
	assign sub = a[3:2];
	assign hit = (a[1:0] == 2'h0) && ((a_ev && sub != 2'h3) || a_mr ||
		(a <= stc_pkg::A_EVFLAG));

	// Per-register write strobes
	logic w_cfg, w_ctrl, w_cnt, w_st, w_rm, w_out, w_flg;
	assign w_cfg = wr && a == stc_pkg::A_CFG;
	assign w_ctrl = wr && a == stc_pkg::A_CTRL;
	assign w_cnt = wr && a == stc_pkg::A_COUNT;
	assign w_st = wr && a == stc_pkg::A_STATE;
	assign w_rm = wr && a == stc_pkg::A_REGMODE;
	assign w_out = wr && a == stc_pkg::A_OUTPUT;
	assign w_flg = wr && a == stc_pkg::A_EVFLAG;

	// Pin inputs: three stages, change taken once stages 2 and 3 agree
	assign in_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & in_q);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			in_q <= '0;
			inp_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			in_q <= in_d;
			inp_q <= in_q;
		end
	end

	// Counter tick and run qualifiers; halves share the tick
	logic unify, tick;
	logic [1:0] isel;
	assign unify = cfg_q[stc_pkg::CFG_UNIFY];
	assign isel = cfg_q[stc_pkg::CFG_INSEL +: 2];
	assign tick = cfg_q[stc_pkg::CFG_INCLK] ?
		(in_q[isel] & ~inp_q[isel]) : 1'b1;
	assign run[0] = ~stop_q[0] & ~halt_q[0];
	assign run[1] = unify ? run[0] : (~stop_q[1] & ~halt_q[1]);
	assign adv = {2{tick}} & run;

	// Match compare on current value; a capture register never matches
	logic [31:0] c32;
	assign c32 = {cnt_q[1], cnt_q[0]};
	for (genvar i = 0; i < NMR; i++) begin : g_mt
		assign mtq[0][i] = adv[0] & ~capm_q[i] & (unify ?
			(c32 == mr_q[i]) : (cnt_q[0] == mr_q[i][15:0]));
		assign mtq[1][i] = adv[1] & ~capm_q[i] & ~unify &
			(cnt_q[1] == mr_q[i][31:16]);
	end

	// Event logic, one slice per event
	for (genvar e = 0; e < NEV; e++) begin : g_ev
		stc_pkg::stc_evctl_t c;
		logic h, m, sig, prv, io, term, dok;
		logic [7:0] mv;
		assign c = evc_q[e];
		assign h = unify ? 1'b0 : c.half;
		assign mv = {3'h0, mtq[h]};
		assign m = mv[c.msel] | (c.hold & mlat_q[e]);
		assign sig = c.isout ? out_q[c.iosel] : in_q[c.iosel];
		assign prv = c.isout ? outp_q[c.iosel] : inp_q[c.iosel];
		assign io = (c.cond == stc_pkg::STC_IO_HIGH) ? sig :
			(c.cond == stc_pkg::STC_IO_RISE) ? (sig & ~prv) :
			(c.cond == stc_pkg::STC_IO_FALL) ? (~sig & prv) : ~sig;
		assign term = (c.comb == stc_pkg::STC_CB_OR) ? (m | io) :
			(c.comb == stc_pkg::STC_CB_MATCH) ? m :
			(c.comb == stc_pkg::STC_CB_IO) ? io : (m & io);
		assign dok = (c.dir == stc_pkg::STC_DIR_ANY) ||
			(c.dir == stc_pkg::STC_DIR_UP && !dir_q[h]) ||
			(c.dir == stc_pkg::STC_DIR_DOWN && dir_q[h]);
		// A halted half is frozen until software releases it
		assign ev[e] = evs_q[e][state_q[h]] & dok & ~halt_q[h] &
			term;
		assign ev_hi[e] = h;
		assign ev_irq[e] = eva_q[e].irq;
		assign ev_dma[e] = eva_q[e].dma;
	end

	// Counter controls from events, per half
	for (genvar k = 0; k < 2; k++) begin : g_hc
		logic [NEV-1:0] mine;
		assign mine = ev & (k == 1 ? ev_hi : ~ev_hi);
		assign lim[k] = |(mine & msk_q[0][16*k +: NEV]) |
			(cfg_q[stc_pkg::CFG_ALIM + k] & mtq[k][0]);
		assign hset[k] = |(mine & msk_q[1][16*k +: NEV]);
		assign sset[k] = |(mine & msk_q[2][16*k +: NEV]);
		assign sclr[k] = |(mine & msk_q[3][16*k +: NEV]);
	end

	// Next count; the 32-bit form steps through half zero's controls
	logic [32:0] stp0, stp1;
	assign stp0 = stc_step(unify ? c32 : {16'h0, cnt_q[0]}, bid_q[0],
		dir_q[0], lim[0]);
	assign stp1 = stc_step({16'h0, cnt_q[1]}, bid_q[1], dir_q[1], lim[1]);
	assign nxt[0] = stp0[15:0];
	assign nxt[1] = unify ? stp0[31:16] : stp1[15:0];
	assign clr[0] = w_ctrl & pwdata_in[stc_pkg::CT_CLR];
	assign clr[1] = w_ctrl & pwdata_in[unify ? stc_pkg::CT_CLR :
		stc_pkg::HALF + stc_pkg::CT_CLR];

	// Counter and direction
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_q <= '{default: 16'h0};
			dir_q <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (clr[k]) begin
					cnt_q[k] <= 16'h0;
					dir_q[k] <= 1'b0;
				end else if (w_cnt) begin
					cnt_q[k] <= pwdata_in[16*k +: 16];
				end else if (adv[k]) begin
					cnt_q[k] <= nxt[k];
					dir_q[k] <= (k == 0) ? stp0[32] : stp1[32];
				end
			end
		end
	end

	// Run controls; event sets win over software, stop over start
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			halt_q <= stc_pkg::RST_HALT;
			stop_q <= 2'h0;
			bid_q <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (w_ctrl) begin
					halt_q[k] <= pwdata_in[16*k + stc_pkg::CT_HALT] | hset[k];
					stop_q[k] <= pwdata_in[16*k + stc_pkg::CT_STOP] | sset[k];
					bid_q[k] <= pwdata_in[16*k + stc_pkg::CT_BIDIR];
				end else begin
					halt_q[k] <= halt_q[k] | hset[k];
					stop_q[k] <= sset[k] | (stop_q[k] & ~sclr[k]);
				end
			end
		end
	end

	// State load, later event wins; no clear on wrap or limit
	always_comb begin
		state_d = state_q;
		if (w_st) begin
			state_d[0] = pwdata_in[2:0];
			state_d[1] = pwdata_in[18:16];
		end
		for (int e = 0; e < NEV; e++) begin
			if (ev[e] && evc_q[e].stld) begin
				state_d[ev_hi[e]] = evc_q[e].stv;
			end
		end
	end

	// Output toggles and capture requests gathered from events
	always_comb begin
		tg = '0;
		cp = '0;
		for (int e = 0; e < NEV; e++) begin
			if (ev[e]) begin
				tg = tg | eva_q[e].tog;
				cp = cp | eva_q[e].cap;
			end
		end
	end
	assign out_d = (w_out ? pwdata_in[NIO-1:0] : out_q) ^ tg;

	// State, outputs, match hold and flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= '{default: 3'h0};
			out_q <= '0;
			outp_q <= '0;
			mlat_q <= '0;
			flag_q <= '0;
		end else begin
			state_q <= state_d;
			out_q <= out_d;
			outp_q <= out_q;
			for (int e = 0; e < NEV; e++) begin
				mlat_q[e] <= ~ev[e] & (mlat_q[e] |
					mtq[ev_hi[e]][evc_q[e].msel % NMR] &
					(evc_q[e].msel < 3'(NMR)));
			end
			flag_q <= (flag_q & ~(w_flg ? pwdata_in[NEV-1:0] : '0)) | ev;
		end
	end

	// Match / capture registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mr_q <= '{default: 32'h0};
			capm_q <= '0;
		end else begin
			if (w_rm) begin
				capm_q <= pwdata_in[NMR-1:0];
			end
			for (int i = 0; i < NMR; i++) begin
				if (capm_q[i] && cp[i]) begin
					mr_q[i] <= c32;
				end else if (wr && a_mr && mi == 3'(i)) begin
					mr_q[i] <= pwdata_in;
				end
			end
		end
	end

	// Configuration and per-event words
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_q <= stc_pkg::RST_CFG;
			msk_q <= '{default: 32'h0};
			evs_q <= '{default: 8'h0};
			evc_q <= '{default: '0};
			eva_q <= '{default: '0};
		end else begin
			if (w_cfg) begin
				cfg_q <= pwdata_in[5:0];
			end
			for (int k = 0; k < 4; k++) begin
				if (wr && a == stc_pkg::A_MSK0 + 12'(4*k)) begin
					msk_q[k] <= pwdata_in & stc_pkg::MSK_WORD;
				end
			end
			if (wr && a_ev && sub == stc_pkg::EV_STM) begin
				evs_q[ei] <= pwdata_in[7:0];
			end
			if (wr && a_ev && sub == stc_pkg::EV_CTL) begin
				evc_q[ei] <= pwdata_in[$bits(stc_pkg::stc_evctl_t)-1:0];
			end
			if (wr && a_ev && sub == stc_pkg::EV_ACT) begin
				eva_q[ei] <= pwdata_in[$bits(stc_pkg::stc_evact_t)-1:0];
			end
		end
	end

	// Read data selection
	always_comb begin
		rd = 32'h0;
		if (a_ev) begin
			unique case (sub)
				stc_pkg::EV_STM: rd = {24'h0, evs_q[ei]};
				stc_pkg::EV_CTL: rd = 32'(evc_q[ei]);
				stc_pkg::EV_ACT: rd = 32'(eva_q[ei]);
				default: rd = 32'h0;
			endcase
		end else if (a_mr) begin
			rd = mr_q[mi];
		end else begin
			unique case (a)
				stc_pkg::A_CFG: rd = {26'h0, cfg_q};
				stc_pkg::A_CTRL: rd = {13'h0, bid_q[1], halt_q[1], stop_q[1],
					13'h0, bid_q[0], halt_q[0], stop_q[0]};
				stc_pkg::A_COUNT: rd = c32;
				stc_pkg::A_STATE: rd = {13'h0, state_q[1], 13'h0, state_q[0]};
				stc_pkg::A_INPUT: rd = {20'h0, out_q, 4'h0, in_q};
				stc_pkg::A_REGMODE: rd = {27'h0, capm_q};
				stc_pkg::A_OUTPUT: rd = {28'h0, out_q};
				stc_pkg::A_EVFLAG: rd = {26'h0, flag_q};
				default: rd = (a >= stc_pkg::A_MSK0 && a < stc_pkg::A_COUNT) ?
					msk_q[a[3:2] - 2'h2] : 32'h0;
			endcase
		end
	end

	// Bus answer and registered side outputs
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			irq_q <= 1'b0;
			dma_q <= '0;
			adc_q <= 1'b0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc & ~hit;
			prdata_q <= (acc && !pwrite_in) ? (hit ? rd : 32'h0) : prdata_q;
			irq_q <= |(flag_q & ev_irq);
			dma_q <= ev & ev_dma;
			adc_q <= |(out_q | gp_match_in);
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign pin_out = out_q;
	assign irq_out = irq_q;
	assign dma_req_out = dma_q;
	assign adc_trig_out = adc_q;
endmodule // stc_core

// >>> tb/stc_core_chk.sv
`timescale 1ns/10ps
module stc_core_chk (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic psel_in, // Select
	input wire logic penable_in, // Enable
	input wire logic pwrite_in, // Write
	input wire logic [11:0] paddr_in, // Address
	input wire logic [31:0] pwdata_in, // Write data
	input wire logic [31:0] prdata_out, // Read data
	input wire logic pready_out, // Ready
	input wire logic pslverr_out, // Error
	input wire logic [stc_pkg::NIO-1:0] pin_in, // Inputs
	input wire logic [stc_pkg::NIO-1:0] gp_match_in, // Matches
	input wire logic [stc_pkg::NIO-1:0] pin_out, // Outputs
	input wire logic adc_trig_out, // ADC trigger
	input wire logic irq_out, // Interrupt
	input wire logic [stc_pkg::NEV-1:0] dma_req_out // DMA
);
	// One clock domain, reset masks all but the reset check
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// Reset check must see reset itself, so it overrides the mask
	chk_reset_quiet: assert property (disable iff (1'b0) rst_in |=>
		pin_out == '0 && !irq_out && dma_req_out == '0 && !adc_trig_out)
		else $error("outputs not quiet after reset");
	chk_adc_or: assert property (!$past(rst_in) |->
		adc_trig_out == |$past(pin_out | gp_match_in))
		else $error("adc trigger not the OR of outputs and matches");
	// Bus answer timing
	chk_apb_wait: assert property ($rose(psel_in && penable_in) |->
		!pready_out ##1 pready_out)
		else $error("ready not after one wait state");
	chk_rdy_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	chk_rdy_cause: assert property (
		pready_out |-> $past(psel_in && penable_in))
		else $error("ready without access phase");
	chk_err_pair: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	chk_err_zero: assert property (
		pslverr_out && !$past(pwrite_in) |-> prdata_out == '0)
		else $error("refused read not zero");
	// Read data moves only when a read completes
	chk_rdata_hold: assert property (
		!$past(rst_in) && $changed(prdata_out) |->
		pready_out && !$past(pwrite_in))
		else $error("read data changed outside a read");
endmodule // stc_core_chk

bind stc_core stc_core_chk u_stc_core_chk (.clk_in(clk_in), .rst_in(rst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .pin_in(pin_in),
	.gp_match_in(gp_match_in), .pin_out(pin_out),
	.adc_trig_out(adc_trig_out), .irq_out(irq_out),
	.dma_req_out(dma_req_out));

// >>> tb/stc_far.sv
`timescale 1ns/10ps
module stc_far (
	input wire logic clk_in, // Clock
	input wire logic [3:0] lvl_in, // Wanted pin levels
	input wire logic [3:0] gpm_in, // Wanted match levels
	output logic [3:0] pin_out, // To block inputs
	output logic [3:0] gpm_out // To block matches
);
	// Levels move just after an edge, unrelated to the block's tick
	always_ff @(posedge clk_in) begin
		pin_out <= lvl_in;
		gpm_out <= gpm_in;
	end
endmodule // stc_far

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic clk_in, rst_in, psel, penable, pwrite, e, pready, perr, adc, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv, a;
	logic [3:0] pin_in, gpm_in, pin_out, lvl, gpm;
	logic [5:0] dma;
	int fails, checks, dmas, d0;

	stc_core u_stc_core (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(perr), .pin_in(pin_in), .gp_match_in(gpm_in),
		.pin_out(pin_out), .adc_trig_out(adc), .irq_out(irq),
		.dma_req_out(dma));
	stc_far u_stc_far (.clk_in(clk_in), .lvl_in(lvl), .gpm_in(gpm),
		.pin_out(pin_in), .gpm_out(gpm_in));

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Count DMA pulses of event zero
	always @(posedge clk_in) begin
		if (dma[0] === 1'b1) dmas <= dmas + 1;
	end

	task close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			fails++;
			$display("Error at %0t seen %h expected %h", $time, s, x);
		end
	endtask
	// Bus transfer; the request stands until ready is sampled high
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			close_out();
		end
		rv = prdata;
		e = perr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task rd(input logic [11:0] ad);
		apb(1'b0, ad, 32'h0);
	endtask
	task wt(input int c);
		repeat (c) @(posedge clk_in);
	endtask
	task rst;
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask
	// Bounded wait for an output level
	task wpin(input int i, input logic v);
		int n;
		n = 0;
		while (pin_out[i] !== v && n < 300) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 300) begin
			fails++;
			close_out();
		end
	endtask

	task t_reset;
		rd(stc_pkg::A_CTRL);
		cmp(rv, 32'h0002_0002);
		rd(stc_pkg::A_COUNT);
		cmp(rv, 32'h0);
		rd(stc_pkg::A_STATE);
		cmp(rv, 32'h0);
		rd(stc_pkg::A_EV0);
		cmp(rv, 32'h0);
		rd(12'h030);
		cmp(32'(e), 32'h1);
		cmp(rv, 32'h0);
		$display("t_reset done");
	endtask
	// Carry across halves only when unified
	task t_cnt;
		wr(stc_pkg::A_CFG, 32'h1);
		wr(stc_pkg::A_COUNT, 32'h0000_FFFF);
		wr(stc_pkg::A_CTRL, 32'h0);
		rd(stc_pkg::A_COUNT);
		a = rv;
		rd(stc_pkg::A_COUNT);
		cmp(32'(a[31:16]), 32'h1);
		cmp(rv - a, 32'h4);
		rst();
		wr(stc_pkg::A_COUNT, 32'h0000_FFFF);
		wr(stc_pkg::A_CTRL, 32'h0002_0000);
		rd(stc_pkg::A_COUNT);
		cmp(32'(rv[31:16]), 32'h0);
		$display("t_cnt done");
	endtask
	// Up-down with match zero as limit
	task t_dir;
		wr(stc_pkg::A_CFG, 32'h11);
		wr(stc_pkg::A_MR0, 32'h40);
		wr(stc_pkg::A_COUNT, 32'h3E);
		wr(stc_pkg::A_CTRL, 32'h4);
		rd(stc_pkg::A_COUNT);
		rd(stc_pkg::A_COUNT);
		a = rv;
		rd(stc_pkg::A_COUNT);
		cmp(a - rv, 32'h4);
		cmp(32'(a <= 32'h40), 32'h1);
		$display("t_dir done");
	endtask
	// Match events, state masks, state load across limit
	task t_evt;
		wr(stc_pkg::A_MR0, 32'h30);
		wr(stc_pkg::A_MR0 + 12'h004, 32'h10);
		wr(stc_pkg::A_MR0 + 12'h008, 32'h8);
		wr(stc_pkg::A_EV0, 32'h1);
		wr(stc_pkg::A_EV0 + 12'h004, 32'h1A01);
		wr(stc_pkg::A_EV0 + 12'h008, 32'h601);
		wr(stc_pkg::A_EV0 + 12'h010, 32'h2);
		wr(stc_pkg::A_EV0 + 12'h014, 32'h202);
		wr(stc_pkg::A_EV0 + 12'h018, 32'h2);
		wr(stc_pkg::A_CFG, 32'h11);
		d0 = dmas;
		wr(stc_pkg::A_CTRL, 32'h0);
		wpin(0, 1'b1);
		cmp(32'(pin_out[1]), 32'h0);
		wpin(1, 1'b1);
		cmp(32'(pin_out[1]), 32'h1);
		rd(stc_pkg::A_STATE);
		cmp(rv, 32'h1);
		cmp(32'(dmas - d0), 32'h1);
		cmp(32'(irq), 32'h1);
		wr(stc_pkg::A_EVFLAG, 32'h3F);
		wt(3);
		cmp(32'(irq), 32'h0);
		$display("t_evt done");
	endtask
	// Input edge event with capture, and the ADC trigger path
	task t_io;
		gpm <= 4'h1;
		wt(3);
		cmp(32'(adc), 32'h1);
		gpm <= 4'h0;
		wt(3);
		cmp(32'(adc), 32'h0);
		wr(stc_pkg::A_CFG, 32'h1);
		wr(stc_pkg::A_REGMODE, 32'h8);
		wr(stc_pkg::A_EV0 + 12'h020, 32'h1);
		wr(stc_pkg::A_EV0 + 12'h024, 32'h4A7);
		wr(stc_pkg::A_EV0 + 12'h028, 32'h88);
		wr(stc_pkg::A_CTRL, 32'h0);
		lvl <= 4'h4;
		wpin(3, 1'b1);
		cmp(32'(pin_out), 32'h8);
		rd(stc_pkg::A_MR0 + 12'h00C);
		a = rv;
		rd(stc_pkg::A_COUNT);
		cmp(32'(a != 32'h0 && a < rv), 32'h1);
		lvl <= 4'h0;
		$display("t_io done");
	endtask
	// Counter ticks on rising edges of input one only
	task t_inclk;
		wr(stc_pkg::A_CFG, 32'h7);
		wr(stc_pkg::A_CTRL, 32'h0);
		repeat (3) begin
			lvl <= 4'h2;
			wt(8);
			lvl <= 4'h0;
			wt(8);
		end
		rd(stc_pkg::A_COUNT);
		cmp(rv, 32'h3);
		$display("t_inclk done");
	endtask

	initial begin
		fails = 0;
		checks = 0;
		dmas = 0;
		rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lvl = 4'h0;
		gpm = 4'h0;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		rst();
		t_cnt();
		rst();
		t_dir();
		rst();
		t_evt();
		rst();
		t_io();
		rst();
		t_inclk();
		close_out();
	end
endmodule // tb_top
